// >>> inc/ams_defs.svh
// Constants of the mux channel sequencer register block
// Assumes inclusion by the package and the design file
`ifndef AMS_DEFS_SVH
`define AMS_DEFS_SVH
// Register indices, byte address is four times the index
`define AMS_IDX_MODE 8'h1c
`define AMS_IDX_CHAN 8'h1d
`define AMS_IDX_GO 8'h1e
`define AMS_IDX_HALT 8'h1f
`define AMS_IDX_INLINE 8'h2a
`define AMS_IDX_STATUS 8'h40
`define AMS_IDX_MASK 8'h80
`define AMS_IDX_LOOP 8'h82
// Field positions
`define AMS_CH_MSB 2
`define AMS_MODE_MSB 1
`define AMS_STROBE_BIT 0
`define AMS_STAT_RUN_BIT 3
// Reset values
`define AMS_RST_CH 3'h0
`define AMS_RST_MASK 8'h00
`define AMS_RST_BIT 1'b0
// Bus widths and answers
`define AMS_AW 10
`define AMS_RESP_OKAY 2'h0
`define AMS_RESP_SLVERR 2'h2
`define AMS_ALIGN 2'h0
`endif

// >>> inc/ams_pkg.sv
// Types of the mux channel sequencer register block
// Assumes ams_defs.svh on the include path
`include "ams_defs.svh"
package ams_pkg;
   typedef enum logic [1:0] {
      AMS_MANUAL = 2'b00,
      AMS_INLINE = 2'b01,
      AMS_AUTO = 2'b10,
      AMS_CUSTOM = 2'b11
   } ams_mode_t;

   typedef struct packed {
      logic awvalid;
      logic [`AMS_AW-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`AMS_AW-1:0] araddr;
      logic rready;
   } ams_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ams_axi_rsp_t;

   typedef struct packed {
      logic aw_got;
      logic [`AMS_AW-1:0] awaddr;
      logic w_got;
      logic [7:0] wdata;
      logic wlane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      ams_mode_t mode;
      logic [2:0] chan_sel;
      logic inline_en;
      logic [7:0] mask;
      logic loop_en;
      logic running;
      logic [2:0] cur_ch;
   } ams_state_t;
endpackage

// >>> rtl/ams_seq_regs.sv
// Register block and channel sequencer of an eight-input mux
// Assumes an AXI4-Lite master on i_clk and a conversion datapath
// on the same clock that pulses i_conv_done and i_inline_valid
//
// Overview of operation
// - Manual code n routes analog input n
// - Channel write mid-sequence cancels, forces manual mode
// - Go bit one starts auto or custom scan
// - Go bit zero does nothing, never stops
// - Go ignored in manual or inline mode
// - Halt bit one stops scan, zero nothing
// - Halt ignored in manual or inline mode
// - Inline enabled: low three bits of the five-bit SDI code pick channel
// - Mask bit n includes input n in auto scan
// - Channel register upper five bits read zero
// - All control registers reset to zero
// - Mode codes: manual, inline, auto, custom
// - Auto scan ends or loops per loop bit
`include "ams_defs.svh"
module ams_seq_regs (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire ams_pkg::ams_axi_req_t i_axi,
   output ams_pkg::ams_axi_rsp_t o_axi,
   input wire logic i_conv_done,
   input wire logic i_inline_valid,
   input wire logic [4:0] i_inline_code,
   input wire logic [2:0] i_custom_chan,
   output logic [2:0] o_channel,
   output logic o_seq_running,
   output logic o_inline_en,
   output logic [1:0] o_mode
);
   import ams_pkg::*;

   ams_state_t s_q;
   ams_state_t s_d;

   // ----------------------------------------
   // Next enabled input in the auto scan
   // ----------------------------------------
   function automatic logic [3:0] next_ch(
      input logic [7:0] m,
      input logic [2:0] c,
      input logic first,
      input logic wrap
   );
      logic found;
      logic [2:0] r;
      found = 1'b0;
      r = `AMS_RST_CH;
      for (int j = 7; j >= 0; j--) begin
         if (m[j] && (first || (j > int'(c)))) begin
            r = 3'(j);
            found = 1'b1;
         end
      end
      if (!found && wrap) begin
         for (int j = 7; j >= 0; j--) begin
            if (m[j]) begin
               r = 3'(j);
               found = 1'b1;
            end
         end
      end
      return {found, r};
   endfunction

   // ----------------------------------------
   // Combinational next state
   // ----------------------------------------
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic do_wr;
   logic wr_ok;
   logic rd_ok;
   logic sequencing_mode_field;
   logic [3:0] nxt;
   logic [3:0] fst;
   logic [7:0] rd_byte;

   always_comb begin
      s_d = s_q;
      wr_idx = s_q.awaddr[`AMS_AW-1:2];
      rd_idx = i_axi.araddr[`AMS_AW-1:2];
      sequencing_mode_field = s_q.mode[`AMS_MODE_MSB];
      nxt = next_ch(s_q.mask, s_q.cur_ch, 1'b0, s_q.loop_en);
      fst = next_ch(s_q.mask, s_q.cur_ch, 1'b1, 1'b0);
      do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
      wr_ok = 1'b0;
      rd_ok = 1'b1;
      rd_byte = `AMS_RST_MASK;

      // Write address and data taken in either order
      if (i_axi.awvalid && !s_q.aw_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = i_axi.awaddr;
      end
      if (i_axi.wvalid && !s_q.w_got && !s_q.bvalid) begin
         s_d.w_got = 1'b1;
         s_d.wdata = i_axi.wdata[7:0];
         s_d.wlane0 = i_axi.wstrb[0];
      end

      // Sequencer progress: auto on each finished conversion, custom every cycle
      if (s_q.running && i_conv_done) begin
         if (s_q.mode == AMS_AUTO) begin
            if (nxt[3]) begin
               s_d.cur_ch = nxt[2:0];
            end else begin
               s_d.running = 1'b0;
            end
         end
      end
      if (s_q.running && s_q.mode == AMS_CUSTOM) begin
         s_d.cur_ch = i_custom_chan;
      end

      // Inline selection from the first SDI bits
      if (s_q.inline_en && i_inline_valid && !s_q.running) begin
         s_d.cur_ch = i_inline_code[`AMS_CH_MSB:0];
      end

      // Register write, answered two cycles after both halves are accepted
      if (do_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         wr_ok = s_q.awaddr[1:0] == `AMS_ALIGN;
         if (wr_ok) begin
            unique case (wr_idx)
               `AMS_IDX_MODE: begin
                  if (s_q.wlane0) begin
                     s_d.mode = ams_mode_t'(s_q.wdata[`AMS_MODE_MSB:0]);
                     s_d.running = 1'b0;
                  end
               end
               `AMS_IDX_CHAN: begin
                  if (s_q.wlane0) begin
                     s_d.chan_sel = s_q.wdata[`AMS_CH_MSB:0];
                     s_d.cur_ch = s_q.wdata[`AMS_CH_MSB:0];
                     if (s_q.running) begin
                        s_d.running = 1'b0;
                        s_d.mode = AMS_MANUAL;
                     end
                  end
               end
               `AMS_IDX_GO: begin
                  // Zero leaves a running scan alone
                  if (s_q.wlane0 && s_q.wdata[`AMS_STROBE_BIT] && sequencing_mode_field) begin
                     if (s_q.mode == AMS_CUSTOM) begin
                        s_d.running = 1'b1;
                        s_d.cur_ch = i_custom_chan;
                     end else if (fst[3]) begin
                        s_d.running = 1'b1;
                        s_d.cur_ch = fst[2:0];
                     end
                  end
               end
               `AMS_IDX_HALT: begin
                  if (s_q.wlane0 && s_q.wdata[`AMS_STROBE_BIT] && sequencing_mode_field) begin
                     s_d.running = 1'b0;
                  end
               end
               `AMS_IDX_INLINE: begin
                  if (s_q.wlane0) begin
                     s_d.inline_en = s_q.wdata[`AMS_STROBE_BIT];
                  end
               end
               `AMS_IDX_MASK: begin
                  if (s_q.wlane0) begin
                     s_d.mask = s_q.wdata;
                  end
               end
               `AMS_IDX_LOOP: begin
                  if (s_q.wlane0) begin
                     s_d.loop_en = s_q.wdata[`AMS_STROBE_BIT];
                  end
               end
               `AMS_IDX_STATUS: begin
               end
               default: begin
                  wr_ok = 1'b0;
               end
            endcase
         end
         s_d.bresp = wr_ok ? `AMS_RESP_OKAY : `AMS_RESP_SLVERR;
      end
      if (s_q.bvalid && i_axi.bready) begin
         s_d.bvalid = 1'b0;
      end

      // Register read, answered the cycle after the address
      unique case (rd_idx)
         `AMS_IDX_MODE: rd_byte = {6'h00, s_q.mode};
         `AMS_IDX_CHAN: rd_byte = {5'h00, s_q.chan_sel};
         `AMS_IDX_GO: rd_byte = `AMS_RST_MASK;
         `AMS_IDX_HALT: rd_byte = `AMS_RST_MASK;
         `AMS_IDX_INLINE: rd_byte = {7'h00, s_q.inline_en};
         `AMS_IDX_MASK: rd_byte = s_q.mask;
         `AMS_IDX_LOOP: rd_byte = {7'h00, s_q.loop_en};
         `AMS_IDX_STATUS: rd_byte = {4'h0, s_q.running, s_q.cur_ch};
         default: rd_ok = 1'b0;
      endcase
      if (i_axi.araddr[1:0] != `AMS_ALIGN) begin
         rd_ok = 1'b0;
      end
      if (i_axi.arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = {24'h00_0000, rd_ok ? rd_byte : `AMS_RST_MASK};
         s_d.rresp = rd_ok ? `AMS_RESP_OKAY : `AMS_RESP_SLVERR;
      end else if (s_q.rvalid && i_axi.rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q.aw_got <= 1'b0;
         s_q.awaddr <= '0;
         s_q.w_got <= 1'b0;
         s_q.wdata <= `AMS_RST_MASK;
         s_q.wlane0 <= 1'b0;
         s_q.bvalid <= 1'b0;
         s_q.bresp <= `AMS_RESP_OKAY;
         s_q.rvalid <= 1'b0;
         s_q.rdata <= '0;
         s_q.rresp <= `AMS_RESP_OKAY;
         s_q.mode <= AMS_MANUAL;
         s_q.chan_sel <= `AMS_RST_CH;
         s_q.inline_en <= `AMS_RST_BIT;
         s_q.mask <= `AMS_RST_MASK;
         s_q.loop_en <= `AMS_RST_BIT;
         s_q.running <= 1'b0;
         s_q.cur_ch <= `AMS_RST_CH;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_comb begin
      o_axi.awready = !s_q.aw_got && !s_q.bvalid;
      o_axi.wready = !s_q.w_got && !s_q.bvalid;
      o_axi.bvalid = s_q.bvalid;
      o_axi.bresp = s_q.bresp;
      o_axi.arready = !s_q.rvalid;
      o_axi.rvalid = s_q.rvalid;
      o_axi.rdata = s_q.rdata;
      o_axi.rresp = s_q.rresp;
   end

   assign o_channel = s_q.cur_ch;
   assign o_seq_running = s_q.running;
   assign o_inline_en = s_q.inline_en;
   assign o_mode = s_q.mode;
endmodule

// >>> testbench/ams_seq_regs_asserts.sv
// Checker of the mux sequencer register block
// Assumes binding to ams_seq_regs, one clock domain
module ams_seq_regs_asserts (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire ams_pkg::ams_axi_req_t i_axi,
   input wire ams_pkg::ams_axi_rsp_t o_axi,
   input wire logic i_conv_done,
   input wire logic i_inline_valid,
   input wire logic [4:0] i_inline_code,
   input wire logic [2:0] i_custom_chan,
   input wire logic [2:0] o_channel,
   input wire logic o_seq_running,
   input wire logic o_inline_en,
   input wire logic [1:0] o_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   import ams_pkg::*;
   // ---
   // Checks
   // ---
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic idle;
   logic [2:0] inl;
   // No register write lands at the next edge
   assign idle = o_axi.awready || o_axi.wready || o_axi.bvalid;
   assign inl = i_inline_code[2:0];
   AST_RST: assert property ($fell(i_rst) |-> o_channel == 3'h0
      && !o_seq_running && o_mode == 2'h0) else $error("state not clear after reset");
   AST_RUN: assert property ($rose(o_seq_running) |-> o_mode[1])
      else $error("scan started outside auto or custom");
   AST_HOLD: assert property (o_seq_running && o_mode == 2'h2 && !i_conv_done
      && idle |=> $stable(o_channel)) else $error("auto channel moved without conversion");
   AST_CUS: assert property (o_seq_running && o_mode == 2'h3 ##1 o_seq_running
      |-> o_channel == $past(i_custom_chan)) else $error("custom channel not followed");
   AST_INL: assert property (o_inline_en && !o_seq_running && i_inline_valid && idle
      |=> o_channel == $past(inl)) else $error("inline code not loaded");
   AST_WLAT: assert property (i_axi.awvalid && o_axi.awready && i_axi.wvalid
      && o_axi.wready |=> !o_axi.bvalid ##1 o_axi.bvalid) else $error("write answer late");
   AST_RLAT: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
      else $error("read answer late");
   AST_UPPER: assert property (o_axi.rvalid |-> o_axi.rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   cover property ($rose(o_seq_running) && o_mode == 2'h2);
   cover property ($rose(o_seq_running) && o_mode == 2'h3);
   cover property (o_inline_en && i_inline_valid);
endmodule

bind ams_seq_regs ams_seq_regs_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_axi(i_axi),
   .o_axi(o_axi), .i_conv_done(i_conv_done), .i_inline_valid(i_inline_valid),
   .i_inline_code(i_inline_code), .i_custom_chan(i_custom_chan), .o_channel(o_channel),
   .o_seq_running(o_seq_running), .o_inline_en(o_inline_en), .o_mode(o_mode));

// >>> testbench/ams_dp_model.sv
// Conversion datapath model beside the sequencer
// Assumes requests from the bench on the rising edge
module ams_dp_model (
   input wire logic i_clk,
   input wire logic i_conv,
   input wire logic i_sel,
   input wire logic [4:0] i_code,
   output logic o_done,
   output logic o_valid,
   output logic [4:0] o_code
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---
   // Pulses one cycle after request
   // ---
   initial {o_done, o_valid, o_code} = 7'h0a;
   always @(posedge i_clk) begin
      o_done <= i_conv;
      o_valid <= i_sel;
      o_code <= i_sel ? i_code : ~o_code;
   end
endmodule

// >>> testbench/ams_seq_regs_bench.sv
// Self-checking bench of the mux sequencer register block
// Assumes ams_pkg, the design and the datapath model compiled
module ams_seq_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import ams_pkg::*;
   logic i_clk = 0, i_rst = 1, cv = 0, sel = 0, done, ival, run, ien;
   logic [4:0] code = 5'h0, icode;
   logic [2:0] cch = 3'h0, ch;
   logic [1:0] md;
   logic [7:0] ri [5] = '{8'h1d, 8'h1e, 8'h1f, 8'h2a, 8'h80};
   ams_axi_req_t rq = '0;
   ams_axi_rsp_t rs;
   int fails = 0, cmp_count = 0;
   ams_seq_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_axi(rq), .o_axi(rs),
      .i_conv_done(done), .i_inline_valid(ival), .i_inline_code(icode),
      .i_custom_chan(cch), .o_channel(ch), .o_seq_running(run), .o_inline_en(ien),
      .o_mode(md));
   ams_dp_model u_dp (.i_clk(i_clk), .i_conv(cv), .i_sel(sel), .i_code(code),
      .o_done(done), .o_valid(ival), .o_code(icode));
   initial forever #25 i_clk = ~i_clk;
   // ---
   // Bus and check tasks
   // ---
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic out(input logic [2:0] c, input logic r);
      chk(ch, c);
      chk(run, r);
   endtask
   task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er = 2'h0);
      logic aw_now;
      logic w_now;
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge i_clk);
      rq.awaddr <= {ix, 2'h0};
      rq.wdata <= {24'h0, d};
      rq.wstrb <= 4'hf;
      {rq.awvalid, rq.wvalid, rq.bready} <= 3'h7;
      do begin
         @(negedge i_clk);
         aw_now = rq.awvalid && rs.awready === 1'b1;
         w_now = rq.wvalid && rs.wready === 1'b1;
         @(posedge i_clk);
         rq.awvalid <= rq.awvalid && !aw_now;
         rq.wvalid <= rq.wvalid && !w_now;
         aw_done = aw_done || aw_now;
         w_done = w_done || w_now;
      end while (!(aw_done && w_done));
      do @(negedge i_clk); while (rs.bvalid !== 1'b1);
      chk(rs.bresp, er);
      @(posedge i_clk);
      rq.bready <= 1'b0;
      @(negedge i_clk);
   endtask
   task automatic rd(input logic [7:0] ix, input logic [7:0] ex, input logic [1:0] er = 2'h0);
      @(posedge i_clk);
      rq.araddr <= {ix, 2'h0};
      {rq.arvalid, rq.rready} <= 2'h3;
      do @(negedge i_clk); while (rs.arready !== 1'b1);
      @(posedge i_clk);
      rq.arvalid <= 1'b0;
      do @(negedge i_clk); while (rs.rvalid !== 1'b1);
      chk(rs.rdata, {24'h0, ex});
      chk(rs.rresp, er);
      @(posedge i_clk);
      rq.rready <= 1'b0;
      @(negedge i_clk);
   endtask
   task automatic pul(input logic c);
      @(posedge i_clk);
      cv <= c;
      sel <= !c;
      @(posedge i_clk);
      {cv, sel} <= 2'h0;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   task automatic end_of_test();
      if (fails == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #500000;
      fails++;
      end_of_test();
   end
   // ---
   // Tests
   // ---
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      out(3'h0, 1'b0);
      chk(md, 2'h0);
      foreach (ri[k]) rd(ri[k], 8'h00);
      rd(8'h50, 8'h00, 2'h2);
      for (int n = 0; n < 8; n++) begin
         wr(8'h1d, 8'hf8 | n[7:0]);
         out(n[2:0], 1'b0);
         rd(8'h1d, n[7:0]);
      end
      for (int m = 0; m < 4; m++) begin
         wr(8'h1c, m[7:0]);
         chk(md, m[1:0]);
         rd(8'h1c, m[7:0]);
      end
      wr(8'h80, 8'h24);
      rd(8'h80, 8'h24);
      for (int m = 0; m < 2; m++) begin
         wr(8'h1c, m[7:0]);
         wr(8'h1e, 8'h01);
         wr(8'h1f, 8'h01);
         out(3'h7, 1'b0);
      end
      wr(8'h1c, 8'h02);
      wr(8'h1e, 8'h01);
      out(3'h2, 1'b1);
      rd(8'h1e, 8'h00);
      wr(8'h1e, 8'h00);
      out(3'h2, 1'b1);
      pul(1'b1);
      out(3'h5, 1'b1);
      pul(1'b1);
      out(3'h5, 1'b0);
      wr(8'h82, 8'h01);
      rd(8'h82, 8'h01);
      wr(8'h1e, 8'h01);
      pul(1'b1);
      pul(1'b1);
      out(3'h2, 1'b1);
      rd(8'h40, 8'h0a);
      pul(1'b1);
      wr(8'h1e, 8'h01);
      out(3'h2, 1'b1);
      wr(8'h1f, 8'h00);
      out(3'h2, 1'b1);
      wr(8'h1f, 8'h01);
      out(3'h2, 1'b0);
      rd(8'h1f, 8'h00);
      wr(8'h1e, 8'h01);
      wr(8'h1d, 8'h03);
      out(3'h3, 1'b0);
      chk(md, 2'h0);
      @(posedge i_clk) cch <= 3'h6;
      wr(8'h1c, 8'h03);
      wr(8'h1e, 8'h01);
      out(3'h6, 1'b1);
      wr(8'h1f, 8'h01);
      out(3'h6, 1'b0);
      wr(8'h2a, 8'h01);
      rd(8'h2a, 8'h01);
      chk(ien, 1'b1);
      @(posedge i_clk) code <= 5'h1c;
      pul(1'b0);
      out(3'h4, 1'b0);
      @(posedge i_clk) i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      out(3'h0, 1'b0);
      chk(md, 2'h0);
      chk(ien, 1'b0);
      foreach (ri[k]) rd(ri[k], 8'h00);
      end_of_test();
   end
endmodule
